// *** flash_status_register_protect.sv ***
// Purpose: Status register bank, serial status read and write protection.
// Assumes: Link in SPI mode 0 or 3; core events are one-cycle pulses.
// Notes: Link logic is clocked by the serial clock and reset by select.
`timescale 1ns/1ps
`default_nettype none

module flash_status_register_protect (
  input wire logic core_clk_i, // Core clock, 20 MHz
  input wire logic reset_i, // Power-up reset, async, active high
  input wire logic spi_sclk_i, // Serial clock from host
  input wire logic spi_cs_n_i, // Chip select, active low
  input wire logic spi_si_i, // Serial data in
  output logic spi_so_o, // Serial data out
  output logic spi_so_oe_n_o, // Output enable, low drives
  input wire logic wp_n_i, // Write protect pin, active low
  input wire logic busy_i, // Internal operation running
  input wire logic erase_suspended_i, // Erase held in suspend
  input wire logic program_suspended_i, // Program held in suspend
  input wire logic wr_enable_i, // Write enable finished, pulse
  input wire logic wr_disable_i, // Write disable finished, pulse
  input wire logic write_op_end_i, // Write-type op done or aborted, pulse
  input wire logic opcode_abort_i, // Frame aborted, pulse
  input wire logic opcode_whole_i, // Abort had a full write-type opcode
  input wire logic sr_write_req_i, // Status write request, pulse
  input wire logic [7:0] sr_write_one_i, // New status byte one
  input wire logic [7:0] sr_write_two_i, // New status byte two
  output logic sr_write_done_o, // Status write accepted, pulse
  output logic sr_write_refused_o, // Status write refused, pulse
  output logic modify_permit_o, // Program/erase allowed (latch); status write also needs sr_writable
  output logic [2:0] page_permit_o, // Per security page modify allowed
  output logic quad_enable_o, // Control pins act as data lines
  output logic [4:0] block_protect_o, // Protect fields for range table
  output logic complement_protect_o, // Inverts the protected range
  output logic [7:0] status_one_o, // Live status byte one
  output logic [7:0] status_two_o // Live status byte two
);

  // Writable status fields, core domain
  logic prot_lock_lo_q; // Low protection lock
  logic prot_lock_hi_q; // High protection lock
  logic [4:0] block_protect_q; // Granularity, top/bottom, size
  logic complement_protect_q; // Complement of protected range
  logic [2:0] page_lock_q; // Security page locks three..one
  logic quad_enable_q; // Quad pin mode
  logic write_enable_latch_q; // Write enable latch

  // Pin synchroniser for write protect
  logic wp_meta_q; // First stage, read only by second
  logic wp_sync_q; // Safe level

  // Status snapshot handed to the link domain
  logic [15:0] status_q; // {byte two, byte one}
  logic [7:0] status_one_d; // Assembled byte one
  logic [7:0] status_two_d; // Assembled byte two

  // Write decision
  logic sr_writable; // Protection allows a write now
  logic wp_effective; // Pin level as seen by protection

  // Link domain state
  logic link_rst; // Frame end or power reset
  logic [3:0] bit_cnt_q; // Opcode bits received
  logic [6:0] opc_q; // Opcode shift register
  flash_status_pkg::read_sel_t read_sel_q; // Which byte is being read
  logic [15:0] stat_meta_q; // Crossing first stage
  logic [15:0] stat_mid_q; // Crossing second stage
  logic [15:0] stat_prev_q; // Second stage, one edge older
  logic [15:0] stat_sync_q; // Accepted stable word
  logic [2:0] out_cnt_q; // Bit position within output byte
  logic [7:0] shift_q; // Output shift register
  logic so_q; // Registered serial output
  logic oe_n_q; // Registered output enable

  // Protection table as one decision
  function automatic logic sr_write_ok(input logic write_enable_latch, input logic hi, input logic lo,
                                       input logic wp);
    logic ok;
    ok = 1'b0;
    case ({hi, lo})
      2'b00: ok = write_enable_latch; // Software protected
      2'b01: ok = write_enable_latch & wp; // Pin decides
      default: ok = 1'b0; // Lock-down, refuse
    endcase
    return ok;
  endfunction

  // Write protect pin enters through two flops
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_meta_q <= 1'b0;
      wp_sync_q <= 1'b0;
    end else begin
      wp_meta_q <= wp_n_i;
      wp_sync_q <= wp_meta_q;
    end
  end

  // In quad mode the pin carries data, so it no longer protects
  assign wp_effective = quad_enable_q | wp_sync_q;

  // Decide whether a status write may proceed
  assign sr_writable = sr_write_ok(write_enable_latch_q, prot_lock_hi_q, prot_lock_lo_q,
                                   wp_effective);

  // Writable fields; power-up reset ends any lock-down
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prot_lock_lo_q <= 1'b0;
      prot_lock_hi_q <= 1'b0;
      block_protect_q <= flash_status_pkg::BP_RESET;
      complement_protect_q <= 1'b0;
      page_lock_q <= flash_status_pkg::LOCK_RESET;
      quad_enable_q <= 1'b0;
    end else if (sr_write_req_i && sr_writable) begin
      // Only writable bits are taken; latch, busy, suspends ignored
      prot_lock_lo_q <= sr_write_one_i[flash_status_pkg::SR1_PROT_LOCK_LO];
      block_protect_q <= sr_write_one_i[flash_status_pkg::SR1_BP_HI:
                                        flash_status_pkg::SR1_BP_LO];
      complement_protect_q <= sr_write_two_i[flash_status_pkg::SR2_CMP];
      quad_enable_q <= sr_write_two_i[flash_status_pkg::SR2_QE];
      prot_lock_hi_q <= sr_write_two_i[flash_status_pkg::SR2_PROT_LOCK_HI];
      // Locks only ever set: a written zero cannot unlock a page
      page_lock_q <= page_lock_q | sr_write_two_i[flash_status_pkg::SR2_LOCK_HI:
                                                  flash_status_pkg::SR2_LOCK_LO];
    end
  end

  // Write enable latch; a set in the same cycle as a clear wins
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      write_enable_latch_q <= 1'b0;
    end else if (wr_enable_i) begin
      write_enable_latch_q <= 1'b1;
    end else if (wr_disable_i || write_op_end_i || sr_write_req_i) begin
      write_enable_latch_q <= 1'b0;
    end else if (opcode_abort_i && opcode_whole_i) begin
      // Partial or unknown opcode leaves the latch alone
      write_enable_latch_q <= 1'b0;
    end
  end

  // Status write answer pulses
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sr_write_done_o <= 1'b0;
      sr_write_refused_o <= 1'b0;
    end else begin
      sr_write_done_o <= sr_write_req_i & sr_writable;
      sr_write_refused_o <= sr_write_req_i & ~sr_writable;
    end
  end

  // Assemble the live status bytes
  always_comb begin
    status_one_d = flash_status_pkg::BYTE_RESET;
    status_one_d[flash_status_pkg::SR1_PROT_LOCK_LO] = prot_lock_lo_q;
    status_one_d[flash_status_pkg::SR1_BP_HI:flash_status_pkg::SR1_BP_LO] = block_protect_q;
    status_one_d[flash_status_pkg::SR1_WEL] = write_enable_latch_q;
    status_one_d[flash_status_pkg::SR1_BUSY] = busy_i;
    status_two_d = flash_status_pkg::BYTE_RESET;
    status_two_d[flash_status_pkg::SR2_ERASE_SUSP] = erase_suspended_i;
    status_two_d[flash_status_pkg::SR2_CMP] = complement_protect_q;
    status_two_d[flash_status_pkg::SR2_LOCK_HI:flash_status_pkg::SR2_LOCK_LO] = page_lock_q;
    status_two_d[flash_status_pkg::SR2_PROG_SUSP] = program_suspended_i;
    status_two_d[flash_status_pkg::SR2_QE] = quad_enable_q;
    status_two_d[flash_status_pkg::SR2_PROT_LOCK_HI] = prot_lock_hi_q;
  end

  // Snapshot in flops so the crossing never sees combinational glitches
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_q <= flash_status_pkg::STATUS_RESET;
    end else begin
      status_q <= {status_two_d, status_one_d};
    end
  end

  // Core-facing outputs
  assign status_one_o = status_q[7:0];
  assign status_two_o = status_q[15:8];
  assign modify_permit_o = write_enable_latch_q;
  assign page_permit_o = {3{write_enable_latch_q}} & ~page_lock_q;
  assign quad_enable_o = quad_enable_q;
  // Range lookup lives outside; only the raw fields leave here
  assign block_protect_o = block_protect_q;
  assign complement_protect_o = complement_protect_q;

  // Link logic restarts whenever select is released
  assign link_rst = spi_cs_n_i | reset_i;

  // Opcode capture on rising serial clock
  always_ff @(posedge spi_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_q <= 4'h0;
      opc_q <= 7'h00;
    end else if (bit_cnt_q != flash_status_pkg::OPCODE_BITS) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      opc_q <= {opc_q[5:0], spi_si_i};
    end
  end

  // Opcode decode on the eighth rising edge
  always_ff @(posedge spi_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      read_sel_q <= flash_status_pkg::READ_NONE;
    end else if (bit_cnt_q == flash_status_pkg::OPCODE_LAST) begin
      if ({opc_q, spi_si_i} == flash_status_pkg::OPC_READ_STATUS_ONE) begin
        read_sel_q <= flash_status_pkg::READ_ONE;
      end else if ({opc_q, spi_si_i} == flash_status_pkg::OPC_READ_STATUS_TWO) begin
        read_sel_q <= flash_status_pkg::READ_TWO;
      end else begin
        read_sel_q <= flash_status_pkg::READ_NONE;
      end
    end
  end

  // Status crosses as levels; clock only runs in frames, but eight
  // opcode edges always refill every stage before the first output bit
  // A word is taken only when two samples in a row agree, so a status
  // write landing mid-crossing never hands out a mix of old and new bits
  always_ff @(posedge spi_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      stat_meta_q <= flash_status_pkg::STATUS_RESET;
      stat_mid_q <= flash_status_pkg::STATUS_RESET;
      stat_prev_q <= flash_status_pkg::STATUS_RESET;
      stat_sync_q <= flash_status_pkg::STATUS_RESET;
    end else begin
      stat_meta_q <= status_q;
      stat_mid_q <= stat_meta_q;
      stat_prev_q <= stat_mid_q;
      if (stat_mid_q == stat_prev_q) begin
        // Settled word only; a torn one waits an edge
        stat_sync_q <= stat_mid_q;
      end
    end
  end

  // Output shifting on falling serial clock, independent of busy
  always_ff @(negedge spi_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      out_cnt_q <= flash_status_pkg::BYTE_FIRST;
      shift_q <= flash_status_pkg::BYTE_RESET;
      so_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else begin
      case (read_sel_q)
        flash_status_pkg::READ_ONE, flash_status_pkg::READ_TWO: begin
          oe_n_q <= 1'b0;
          // Counter wraps after bit zero back to bit seven
          out_cnt_q <= out_cnt_q + 3'h1;
          if (out_cnt_q == flash_status_pkg::BYTE_FIRST) begin
            // Fresh sample at every byte start
            if (read_sel_q == flash_status_pkg::READ_ONE) begin
              so_q <= stat_sync_q[7];
              shift_q <= {stat_sync_q[6:0], 1'b0};
            end else begin
              so_q <= stat_sync_q[15];
              shift_q <= {stat_sync_q[14:8], 1'b0};
            end
          end else begin
            so_q <= shift_q[7];
            shift_q <= {shift_q[6:0], 1'b0};
          end
        end
        default: begin
          oe_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Serial pin drive
  assign spi_so_o = so_q;
  assign spi_so_oe_n_o = oe_n_q;

  // Helper: select seen on core clock, for the float check
  logic cs_meta_q; // First stage, read only by second
  logic cs_sync_q; // Synchronised select
  logic cs_sync2_q; // One more stage, released for two cycles
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_meta_q <= 1'b1;
      cs_sync_q <= 1'b1;
      cs_sync2_q <= 1'b1;
    end else begin
      cs_meta_q <= spi_cs_n_i;
      cs_sync_q <= cs_meta_q;
      cs_sync2_q <= cs_sync_q;
    end
  end

  // Core-domain steps of a status write
  sequence s_write_req_sw;
    sr_write_req_i && !prot_lock_hi_q && !prot_lock_lo_q && write_enable_latch_q;
  endsequence

  sequence s_write_req_hw_locked;
    sr_write_req_i && !prot_lock_hi_q && prot_lock_lo_q && !wp_effective;
  endsequence

  // Pin high (or quad mode) with the low lock set and latch set
  sequence s_write_req_hw_open;
    sr_write_req_i && !prot_lock_hi_q && prot_lock_lo_q && wp_effective &&
      write_enable_latch_q;
  endsequence

  // Answer step of a refused write
  sequence s_answer_refused;
    sr_write_refused_o && !sr_write_done_o;
  endsequence

  a_wel_set_win: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    wr_enable_i |=> write_enable_latch_q
  ) else $error("write enable latch not set");

  a_wel_disable: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (wr_disable_i && !wr_enable_i) |=> !write_enable_latch_q
  ) else $error("write disable did not clear latch");

  a_abort_keep: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (opcode_abort_i && !opcode_whole_i && !wr_disable_i && !write_op_end_i && !sr_write_req_i)
      |=> $stable(write_enable_latch_q)
  ) else $error("partial opcode abort changed latch");

  a_sw_write: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_write_req_sw |=> block_protect_q == $past(sr_write_one_i[flash_status_pkg::SR1_BP_HI:
      flash_status_pkg::SR1_BP_LO]) && sr_write_done_o
  ) else $error("software protected write not taken");

  a_pin_unlock: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_write_req_hw_open |=> sr_write_done_o && !sr_write_refused_o
  ) else $error("pin unprotected write not taken");

  a_hw_refuse: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    s_write_req_hw_locked |=> s_answer_refused ##0 $stable(block_protect_q)
  ) else $error("hardware protected write not refused");

  a_lockdown_refuse: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (sr_write_req_i && prot_lock_hi_q) |=> s_answer_refused ##0 $stable(quad_enable_q)
  ) else $error("write taken during lock-down");

  a_latch_gate: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (sr_write_req_i && !write_enable_latch_q) |=> s_answer_refused
  ) else $error("status write taken with latch clear");

  a_lockdown_hold: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (prot_lock_hi_q && !prot_lock_lo_q) |=> prot_lock_hi_q && !prot_lock_lo_q
  ) else $error("lock-down pair left before power cycle");

  a_page_otp: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    ($past(page_lock_q) & ~page_lock_q) == 3'h0
  ) else $error("security page lock was cleared");

  a_busy_visible: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    busy_i |=> status_one_o[flash_status_pkg::SR1_BUSY]
  ) else $error("busy not shown in status byte one");

  a_so_float: assert property (
    @(posedge core_clk_i) disable iff (reset_i)
    (cs_sync_q && cs_sync2_q) |-> spi_so_oe_n_o
  ) else $error("serial output driven without select");

  a_byte_wrap: assert property (
    @(negedge spi_sclk_i) disable iff (link_rst)
    (read_sel_q != flash_status_pkg::READ_NONE && out_cnt_q == 3'h7)
      |=> out_cnt_q == 3'h0 && !spi_so_oe_n_o
  ) else $error("status byte did not wrap to bit seven");

endmodule

`default_nettype wire

// *** flash_status_pkg.sv ***
// Purpose: Shared constants for the serial flash status register block.
// Assumes: One status write request carries both status bytes at once.
// Notes: Positions are bit numbers inside each 8-bit status byte.
package flash_status_pkg;

  // Read opcodes
  localparam logic [7:0] OPC_READ_STATUS_ONE = 8'h05;
  localparam logic [7:0] OPC_READ_STATUS_TWO = 8'h35;

  // Serial framing
  localparam logic [3:0] OPCODE_BITS = 4'h8;
  localparam logic [3:0] OPCODE_LAST = 4'h7;
  localparam logic [2:0] BYTE_FIRST = 3'h0;

  // Byte one field positions
  localparam int SR1_PROT_LOCK_LO = 7;
  localparam int SR1_BP_HI = 6;
  localparam int SR1_BP_LO = 2;
  localparam int SR1_WEL = 1;
  localparam int SR1_BUSY = 0;

  // Byte two field positions
  localparam int SR2_ERASE_SUSP = 7;
  localparam int SR2_CMP = 6;
  localparam int SR2_LOCK_HI = 5;
  localparam int SR2_LOCK_LO = 3;
  localparam int SR2_PROG_SUSP = 2;
  localparam int SR2_QE = 1;
  localparam int SR2_PROT_LOCK_HI = 0;

  // Reset values of writable fields
  localparam logic [4:0] BP_RESET = 5'h00;
  localparam logic [2:0] LOCK_RESET = 3'h0;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // Which byte the link is reading
  typedef enum logic [1:0] {
    READ_NONE = 2'b00,
    READ_ONE = 2'b01,
    READ_TWO = 2'b10
  } read_sel_t;

endpackage

// *** spi_host_model.sv ***
// Purpose: Host model driving the serial status link in mode 0.
// Assumes: Link clock idles low and only runs inside a frame.
// Notes: Data-in is inverted after the opcode so no stale level lingers.
`timescale 1ns/1ps
`default_nettype none

module spi_host_model #(
  parameter int HALF_NS = 16 // Half of the 32 ns link clock
) (
  output logic spi_sclk_o, // Serial clock to device
  output logic spi_cs_n_o, // Chip select, active low
  output logic spi_si_o, // Serial data to device
  input wire logic spi_so_i, // Serial data from device
  input wire logic spi_so_oe_n_i // Device output enable, low drives
);
  // Idle levels from time zero
  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_si_o = 1'b0;
  end

  // One frame: opcode out, then nbits sampled on rising edges
  // A nonzero gap stretches the low phase to act as a slow host
  task automatic frame(input logic [7:0] opc, input int nbits, input int gap_ns,
                       output logic [15:0] data, output logic drove);
    data = 16'h0000;
    drove = 1'b0;
    spi_cs_n_o = 1'b0;
    #(HALF_NS);
    for (int i = 7; i >= 0; i--) begin
      spi_si_o = opc[i];
      #(HALF_NS) spi_sclk_o = 1'b1;
      #(HALF_NS) spi_sclk_o = 1'b0;
    end
    spi_si_o = ~spi_si_o; // Released line, not the last bit
    for (int i = 0; i < nbits; i++) begin
      #(HALF_NS + gap_ns) spi_sclk_o = 1'b1;
      // A floating line reads as the inverse, so a read while undriven fails
      data = {data[14:0], (spi_so_oe_n_i === 1'b0) ? spi_so_i : ~spi_so_i};
      if (spi_so_oe_n_i === 1'b0) drove = 1'b1;
      #(HALF_NS) spi_sclk_o = 1'b0;
    end
    // Release may fall mid-byte on purpose
    #(HALF_NS) spi_cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** flash_status_register_protect_tb.sv ***
// Purpose: Self-checking bench for the status register and protection block.
// Assumes: Core events are one-cycle pulses driven on falling core edges.
// Notes: Expected bytes are built from the field layout, not read back.
`timescale 1ns/1ps
`default_nettype none

module flash_status_register_protect_tb;
  logic core_clk_i, reset_i, spi_sclk_i, spi_cs_n_i, spi_si_i, wp_n_i, busy_i;
  logic erase_suspended_i, program_suspended_i, wr_enable_i, wr_disable_i;
  logic write_op_end_i, opcode_abort_i, opcode_whole_i, sr_write_req_i;
  logic [7:0] sr_write_one_i, sr_write_two_i, status_one_o, status_two_o;
  logic spi_so_o, spi_so_oe_n_o, sr_write_done_o, sr_write_refused_o;
  logic modify_permit_o, quad_enable_o, complement_protect_o;
  logic [2:0] page_permit_o;
  logic [4:0] block_protect_o;
  logic [15:0] got;
  logic drove;
  int num_errors, num_checks, cycles;
  // Protection walk: byte one, byte two, pin level, accepted
  logic [7:0] w1 [5] = '{8'h80, 8'hFC, 8'h80, 8'h00, 8'h00};
  logic [7:0] w2 [5] = '{8'h00, 8'h7B, 8'h02, 8'h01, 8'h00};
  logic pin [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic ok [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  flash_status_register_protect dut_u (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_si_i(spi_si_i),
    .spi_so_o(spi_so_o), .spi_so_oe_n_o(spi_so_oe_n_o), .wp_n_i(wp_n_i),
    .busy_i(busy_i), .erase_suspended_i(erase_suspended_i),
    .program_suspended_i(program_suspended_i), .wr_enable_i(wr_enable_i),
    .wr_disable_i(wr_disable_i), .write_op_end_i(write_op_end_i),
    .opcode_abort_i(opcode_abort_i), .opcode_whole_i(opcode_whole_i),
    .sr_write_req_i(sr_write_req_i), .sr_write_one_i(sr_write_one_i),
    .sr_write_two_i(sr_write_two_i), .sr_write_done_o(sr_write_done_o),
    .sr_write_refused_o(sr_write_refused_o), .modify_permit_o(modify_permit_o),
    .page_permit_o(page_permit_o), .quad_enable_o(quad_enable_o),
    .block_protect_o(block_protect_o), .complement_protect_o(complement_protect_o),
    .status_one_o(status_one_o), .status_two_o(status_two_o));

  spi_host_model host_u (.spi_sclk_o(spi_sclk_i), .spi_cs_n_o(spi_cs_n_i),
    .spi_si_o(spi_si_i), .spi_so_i(spi_so_o), .spi_so_oe_n_i(spi_so_oe_n_o));

  // 20 MHz core clock
  always #25 core_clk_i = ~core_clk_i;

  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One-cycle event: 0 enable, 1 disable, 2 op end, 3 abort
  task automatic pulse(input int which);
    @(negedge core_clk_i);
    wr_enable_i = (which == 0);
    wr_disable_i = (which == 1);
    write_op_end_i = (which == 2);
    opcode_abort_i = (which == 3);
    @(negedge core_clk_i);
    {wr_enable_i, wr_disable_i, write_op_end_i, opcode_abort_i} = 4'h0;
  endtask

  // Status write; done or refused shows one cycle later
  task automatic sr_write(input logic [7:0] one, input logic [7:0] two, input logic acc);
    @(negedge core_clk_i);
    sr_write_req_i = 1'b1;
    sr_write_one_i = one;
    sr_write_two_i = two;
    @(negedge core_clk_i);
    sr_write_req_i = 1'b0;
    chk({sr_write_done_o, sr_write_refused_o}, {acc, ~acc});
    repeat (2) @(negedge core_clk_i);
    chk(modify_permit_o, 1'b0);
  endtask

  // Power-up reset held for 16 cycles
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (16) @(negedge core_clk_i);
    reset_i = 1'b0;
    @(negedge core_clk_i);
    chk({status_one_o, status_two_o}, 16'h0000);
    chk({modify_permit_o, spi_so_oe_n_o, quad_enable_o}, 3'b010);
  endtask

  // Writable fields land, read-only data bits are ignored
  task automatic t_fields();
    pulse(0);
    chk(modify_permit_o, 1'b1);
    sr_write(8'h57, 8'hC4, 1'b1);
    chk({status_one_o, status_two_o}, 16'h5440);
    chk({block_protect_o, complement_protect_o}, 6'h2B);
  endtask

  // Read byte one twice while busy ends mid-frame
  task automatic t_read_busy();
    @(negedge core_clk_i);
    busy_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    fork
      host_u.frame(8'h05, 16, 0, got, drove);
      begin
        #300;
        @(negedge core_clk_i);
        busy_i = 1'b0;
      end
    join
    chk(got, 16'h5554);
    chk(drove, 1'b1);
  endtask

  // Byte two with both suspends, slow host
  task automatic t_read_two();
    @(negedge core_clk_i);
    erase_suspended_i = 1'b1;
    program_suspended_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    host_u.frame(8'h35, 8, 40, got, drove);
    chk(got[7:0], 8'hC4);
    @(negedge core_clk_i);
    erase_suspended_i = 1'b0;
    program_suspended_i = 1'b0;
  endtask

  // Partial byte, float on release, foreign opcode never drives
  task automatic t_release();
    host_u.frame(8'h05, 3, 0, got, drove);
    chk(got[2:0], 3'b010);
    #1;
    chk(spi_so_oe_n_o, 1'b1);
    host_u.frame(8'h06, 8, 0, got, drove);
    chk(drove, 1'b0);
  endtask

  // Lock pair and pin walk, then power cycle
  task automatic t_protect();
    logic [15:0] e;
    e = 16'h5440;
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk_i);
      wp_n_i = pin[i];
      pulse(0);
      sr_write(w1[i], w2[i], ok[i]);
      if (ok[i]) e = {w1[i] & 8'hFC, w2[i] & 8'h7B};
      chk({status_one_o, status_two_o}, e);
      chk(quad_enable_o, e[1]);
    end
    do_reset();
  endtask

  // Latch set and clear paths
  task automatic t_latch();
    pulse(0);
    opcode_whole_i = 1'b0;
    pulse(3);
    chk(modify_permit_o, 1'b1);
    opcode_whole_i = 1'b1;
    pulse(3);
    chk(modify_permit_o, 1'b0);
    pulse(0);
    pulse(1);
    chk(modify_permit_o, 1'b0);
    pulse(0);
    pulse(2);
    chk(modify_permit_o, 1'b0);
    sr_write(8'h00, 8'h02, 1'b0);
    chk(quad_enable_o, 1'b0);
  endtask

  // Page locks gate modify and never clear by write
  task automatic t_pages();
    pulse(0);
    sr_write(8'h00, 8'h28, 1'b1);
    pulse(0);
    chk(page_permit_o, 3'b010);
    sr_write(8'h00, 8'h00, 1'b1);
    chk(status_two_o, 8'h28);
  endtask

  // Verdict and end of run
  task automatic print_verdict();
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    core_clk_i = 1'b0;
    reset_i = 1'b1;
    {wp_n_i, busy_i, erase_suspended_i, program_suspended_i} = 4'h0;
    {wr_enable_i, wr_disable_i, write_op_end_i, opcode_abort_i} = 4'h0;
    {opcode_whole_i, sr_write_req_i} = 2'b00;
    sr_write_one_i = 8'h00;
    sr_write_two_i = 8'h00;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    do_reset();
    t_fields();
    t_read_busy();
    t_read_two();
    t_release();
    t_protect();
    t_latch();
    t_pages();
    print_verdict();
  end
endmodule
`default_nettype wire
